/* audio_route_consts.svh */
`ifndef AUDIO_ROUTE_CONSTS_SVH
`define AUDIO_ROUTE_CONSTS_SVH

// Register indices; byte address is four times the index.
`define IDX_FRAME_RATE   16'h40eb
`define IDX_OUT_ROUTE    16'h40f3
`define IDX_PIN_ROLE     16'h40f4
`define IDX_RUN          16'h40f6
`define IDX_SERIAL_RATE  16'h40f8
`define IDX_ENGINE_STAT  16'h40f9

// Writable field masks.
`define MASK_FRAME_RATE  8'h0f
`define MASK_OUT_ROUTE   8'h0f
`define MASK_PIN_ROLE    8'h0f
`define MASK_RUN         8'h01
`define MASK_SERIAL_RATE 8'h07

// Reset values.
`define RST_FRAME_RATE   8'h00
`define RST_OUT_ROUTE    8'h00
`define RST_PIN_ROLE     8'h00
`define RST_RUN          8'h00
`define RST_SERIAL_RATE  8'h00

// Pin role bit positions.
`define PIN_FRAME_CLK    3
`define PIN_BIT_CLK      2
`define PIN_SDATA_OUT    1
`define PIN_SDATA_IN     0

// Period of each rate in ticks of the four-times base rate; zero means none.
`define QT_X4            5'h01
`define QT_X2            5'h02
`define QT_X1            5'h04
`define QT_D1P5          5'h06
`define QT_D2            5'h08
`define QT_D3            5'h0c
`define QT_D4            5'h10
`define QT_D6            5'h18
`define QT_NONE          5'h00

// Engine frame-rate codes that follow the serial port rates.
`define FR_SERIAL_IN     4'h7
`define FR_SERIAL_OUT    4'h8

`define SAMPLE_W         24
`define SLOT_COUNT       8
`endif

/* audio_route_pkg.sv */
package audio_route_pkg;
	typedef enum logic [2:0] {
		ENG_STANDBY = 3'b001,
		ENG_ARMED   = 3'b010,
		ENG_RUNNING = 3'b100
	} engine_state_t;

	typedef logic [23:0] sample_t;
endpackage

/* frame_pacer.sv */
`include "audio_route_consts.svh"

// Divides the four-times base rate tick down to a frame pulse.
module frame_pacer (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Rate tick and period in ticks, zero stops pulses.
	input  wire logic       quad_tick,
	input  wire logic [4:0] period,
	// One-cycle frame pulse.
	output logic            frame_pulse
);
	logic [4:0] count_reg;
	logic [4:0] count_next;
	logic       pulse_next;
	wire        wrap = quad_tick && (count_reg + 5'h01 >= period);

	// A period of zero clears the counter to zero so that a later rate starts clean.
	assign count_next = (period == `QT_NONE) ? 5'h00 :
	                    !quad_tick ? count_reg :
	                    wrap ? 5'h00 : count_reg + 5'h01;
	assign pulse_next = (period != `QT_NONE) && wrap;

	// Count and pulse registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg   <= 5'h00;
			frame_pulse <= 1'b0;
		end else begin
			count_reg   <= count_next;
			frame_pulse <= pulse_next;
		end
	end
endmodule

/* audio_route_engine_ctrl.sv */
// Local design decision: register access over APB.
`include "audio_route_consts.svh"

// Serial routing, pin role and engine run control behind an APB slave.
module audio_route_engine_ctrl (
	// Clock and reset.
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Rate tick at four times the base sample rate.
	input  wire logic                 quad_rate_tick,
	// ADC samples.
	input  wire logic [23:0]          adc_left,
	input  wire logic [23:0]          adc_right,
	input  wire logic                 adc_valid,
	// Engine stream in and out.
	input  wire logic [191:0]         engine_slot_data,
	input  wire logic                 engine_slot_valid,
	output logic [23:0]               engine_in_left,
	output logic [23:0]               engine_in_right,
	output logic                      engine_in_valid,
	// Engine control.
	output logic                      engine_frame_start,
	output logic                      engine_pc_enable,
	output logic                      engine_standby,
	// Serial output stream, eight slots; in ADC bypass slot 2p left and 2p+1 right unless route bit 3 swaps them.
	output logic [191:0]              tx_slot_data,
	output logic                      tx_slot_valid,
	output logic                      serial_frame_pulse,
	// Serial port pin drivers from the port logic.
	input  wire logic [3:0]           port_pin_out,
	input  wire logic [3:0]           port_pin_oe_n,
	// Engine auxiliary pin drivers, bit 3 aux_pin_zero down to bit 0 aux_pin_three.
	input  wire logic [3:0]           aux_pin_out,
	input  wire logic [3:0]           aux_pin_oe_n,
	// Pad side, bit 3 frame clock, 2 bit clock, 1 data out, 0 data in.
	input  wire logic [3:0]           pad_in,
	output logic [3:0]                pad_out,
	output logic [3:0]                pad_oe_n,
	output logic [3:0]                pin_is_aux,
	output logic [3:0]                port_pin_in,
	output logic [3:0]                aux_pin_in
);
	// Registers.
	logic [7:0] frame_rate_reg;
	logic [7:0] out_route_reg;
	logic [7:0] pin_role_reg;
	logic [7:0] run_reg;
	logic [7:0] serial_rate_reg;
	audio_route_pkg::engine_state_t state_reg;
	audio_route_pkg::engine_state_t state_next;
	logic [191:0] tx_slot_next;
	logic         tx_valid_next;

	// Period in quad ticks for a serial port rate code.
	function automatic logic [4:0] serial_period(input logic [2:0] code);
		logic [4:0] p;
		p = `QT_NONE;
		unique case (code)
			3'h0: p = `QT_X1;
			3'h1: p = `QT_D6;
			3'h2: p = `QT_D4;
			3'h3: p = `QT_D3;
			3'h4: p = `QT_D2;
			3'h5: p = `QT_D1P5;
			3'h6: p = `QT_X2;
			3'h7: p = `QT_NONE;
		endcase
		return p;
	endfunction

	// Period in quad ticks for an engine frame-rate code.
	function automatic logic [4:0] engine_period(input logic [3:0] code, input logic [2:0] ser);
		logic [4:0] p;
		p = `QT_NONE;
		unique case (code)
			4'h0: p = `QT_X2;
			4'h1: p = `QT_X1;
			4'h2: p = `QT_D1P5;
			4'h3: p = `QT_D2;
			4'h4: p = `QT_D3;
			4'h5: p = `QT_D4;
			4'h6: p = `QT_D6;
			4'h7: p = serial_period(ser);
			4'h8: p = serial_period(ser);
			4'h9: p = `QT_X4;
			default: p = `QT_NONE;
		endcase
		return p;
	endfunction

	// APB decode; one serial port so the input and output rates coincide.
	wire [15:0] reg_idx   = paddr[17:2];
	wire        addr_hit  = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'b00);
	wire        hit_frame = addr_hit && (reg_idx == `IDX_FRAME_RATE);
	wire        hit_route = addr_hit && (reg_idx == `IDX_OUT_ROUTE);
	wire        hit_pin   = addr_hit && (reg_idx == `IDX_PIN_ROLE);
	wire        hit_run   = addr_hit && (reg_idx == `IDX_RUN);
	wire        hit_ser   = addr_hit && (reg_idx == `IDX_SERIAL_RATE);
	wire        hit_stat  = addr_hit && (reg_idx == `IDX_ENGINE_STAT);
	wire        mapped    = hit_frame | hit_route | hit_pin | hit_run | hit_ser | hit_stat;
	wire        setup_ph  = psel && !penable;
	wire        wr_acc    = psel && penable && pwrite && mapped;
	wire [7:0]  wbyte     = pwdata[7:0];
	wire [7:0]  stat_byte = {5'h00, state_reg};

	// Zero-wait slave: read data is caught in setup and shown in access.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Read mux; unused upper bits read zero.
	wire [7:0] rd_byte = hit_frame ? frame_rate_reg :
	                     hit_route ? out_route_reg :
	                     hit_pin   ? pin_role_reg :
	                     hit_run   ? run_reg :
	                     hit_ser   ? serial_rate_reg :
	                     hit_stat  ? stat_byte : 8'h00;

	// Read data register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end

	// Register writes; reserved bits are masked out.
	// reserved bits masked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_rate_reg  <= `RST_FRAME_RATE;
			out_route_reg   <= `RST_OUT_ROUTE;
			pin_role_reg    <= `RST_PIN_ROLE;
			run_reg         <= `RST_RUN;
			serial_rate_reg <= `RST_SERIAL_RATE;
		end else if (wr_acc) begin
			if (hit_frame) frame_rate_reg <= wbyte & `MASK_FRAME_RATE;
			if (hit_route) out_route_reg <= wbyte & `MASK_OUT_ROUTE;
			if (hit_pin) pin_role_reg <= wbyte & `MASK_PIN_ROLE;
			if (hit_run) run_reg <= wbyte & `MASK_RUN;
			if (hit_ser) serial_rate_reg <= wbyte & `MASK_SERIAL_RATE;
		end
	end

	// Rate pacing for the engine and the serial port.
	// none codes give no pulse
	wire [4:0] eng_period = engine_period(frame_rate_reg[3:0], serial_rate_reg[2:0]);
	wire [4:0] ser_period = serial_period(serial_rate_reg[2:0]);
	wire       eng_pulse;

	frame_pacer u_engine_pacer (
		.pclk        (pclk),
		.presetn     (presetn),
		.quad_tick   (quad_rate_tick),
		.period      (eng_period),
		.frame_pulse (eng_pulse)
	);

	frame_pacer u_serial_pacer (
		.pclk        (pclk),
		.presetn     (presetn),
		.quad_tick   (quad_rate_tick),
		.period      (ser_period),
		.frame_pulse (serial_frame_pulse)
	);

	// Engine run state. Dropping run mid-frame cuts the frame short, which is
	// why software parks the frame rate at none before clearing run.
	wire run_bit = run_reg[0];
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			audio_route_pkg::ENG_STANDBY: begin
				if (run_bit) state_next = audio_route_pkg::ENG_ARMED;
			end
			audio_route_pkg::ENG_ARMED: begin
				if (!run_bit) state_next = audio_route_pkg::ENG_STANDBY;
				else if (eng_pulse) state_next = audio_route_pkg::ENG_RUNNING;
			end
			audio_route_pkg::ENG_RUNNING: begin
				if (!run_bit) state_next = audio_route_pkg::ENG_STANDBY;
			end
			default: state_next = audio_route_pkg::ENG_STANDBY;
		endcase
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= audio_route_pkg::ENG_STANDBY;
		end else begin
			state_reg <= state_next;
		end
	end

	// Engine controls follow the state; frames reach it only when enabled.
	// standby blocks frames
	wire eng_enabled = run_bit && (state_reg != audio_route_pkg::ENG_STANDBY);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			engine_frame_start <= 1'b0;
			engine_pc_enable   <= 1'b0;
			engine_standby     <= 1'b1;
		end else begin
			engine_frame_start <= eng_pulse && eng_enabled;
			engine_pc_enable   <= state_next == audio_route_pkg::ENG_RUNNING;
			engine_standby     <= state_next == audio_route_pkg::ENG_STANDBY;
		end
	end

	// Output routing decode.
	wire [3:0] route      = out_route_reg[3:0];
	wire       via_engine = (route == 4'h0);
	wire       bypass     = route[0];
	wire [1:0] pair       = route[2:1];
	wire       swap       = route[3];
	wire [4:0] base_slot  = {2'b00, pair, 1'b0};

	// Slot contents; reserved even codes send nothing.
	always_comb begin
		tx_slot_next  = tx_slot_data;
		tx_valid_next = 1'b0;
		if (via_engine && engine_slot_valid) begin
			tx_slot_next  = engine_slot_data;
			tx_valid_next = 1'b1;
		end else if (bypass && adc_valid) begin
			tx_slot_next  = 192'h0;
			tx_slot_next[base_slot * 24 +: 24]         = swap ? adc_right : adc_left;
			tx_slot_next[(base_slot + 5'h01) * 24 +: 24] = swap ? adc_left : adc_right;
			tx_valid_next = 1'b1;
		end
	end

	// Serial stream and engine feed registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_slot_data    <= 192'h0;
			tx_slot_valid   <= 1'b0;
			engine_in_left  <= 24'h00_0000;
			engine_in_right <= 24'h00_0000;
			engine_in_valid <= 1'b0;
		end else begin
			tx_slot_data    <= tx_slot_next;
			tx_slot_valid   <= tx_valid_next;
			engine_in_left  <= adc_left;
			engine_in_right <= adc_right;
			engine_in_valid <= adc_valid && via_engine;
		end
	end

	// Pin roles: a one hands the pad to the engine auxiliary driver.
	// pin role muxing
	assign pin_is_aux  = pin_role_reg[3:0];
	assign pad_out     = (pin_is_aux & aux_pin_out) | (~pin_is_aux & port_pin_out);
	assign pad_oe_n    = (pin_is_aux & aux_pin_oe_n) | (~pin_is_aux & port_pin_oe_n);
	// Inputs of the unselected owner read zero so it sees no stray edges.
	assign aux_pin_in  = pad_in & pin_is_aux;
	assign port_pin_in = pad_in & ~pin_is_aux;

	// Assertions.
	a_route_engine: assert property (p_route_engine);
	property p_route_engine;
		@(posedge pclk) disable iff (!presetn)
		(via_engine && engine_slot_valid) |=> (tx_slot_valid && tx_slot_data == $past(engine_slot_data));
	endproperty

	a_route_straight: assert property (p_route_straight);
	property p_route_straight;
		@(posedge pclk) disable iff (!presetn)
		(route == 4'h3 && adc_valid) |=> (tx_slot_valid && tx_slot_data[71:48] == $past(adc_left)
			&& tx_slot_data[95:72] == $past(adc_right));
	endproperty

	a_route_swap: assert property (p_route_swap);
	property p_route_swap;
		@(posedge pclk) disable iff (!presetn)
		(route == 4'hf && adc_valid) |=> (tx_slot_data[167:144] == $past(adc_right)
			&& tx_slot_data[191:168] == $past(adc_left));
	endproperty

	a_route_reserved: assert property (p_route_reserved);
	property p_route_reserved;
		@(posedge pclk) disable iff (!presetn)
		(!route[0] && route != 4'h0) |=> !tx_slot_valid;
	endproperty

	a_pin_role: assert property (p_pin_role);
	property p_pin_role;
		@(posedge pclk) disable iff (!presetn)
		pin_role_reg[`PIN_BIT_CLK] |-> (pad_out[2] == aux_pin_out[2] && port_pin_in[2] == 1'b0);
	endproperty

	a_pin_write: assert property (p_pin_write);
	property p_pin_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_pin) |=> (pin_is_aux == $past(pwdata[3:0]));
	endproperty

	a_run_start: assert property (p_run_start);
	property p_run_start;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == audio_route_pkg::ENG_ARMED && run_bit && eng_pulse) |=> ##0 engine_pc_enable ##1 engine_pc_enable || !run_bit;
	endproperty

	a_run_wait: assert property (p_run_wait);
	property p_run_wait;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == audio_route_pkg::ENG_ARMED && !eng_pulse) |=> !engine_pc_enable;
	endproperty

	a_standby: assert property (p_standby);
	property p_standby;
		@(posedge pclk) disable iff (!presetn)
		$fell(run_bit) |=> (engine_standby && !engine_frame_start)[*2];
	endproperty

	a_ser_rate: assert property (p_ser_rate);
	property p_ser_rate;
		@(posedge pclk) disable iff (!presetn)
		(serial_rate_reg[2:0] == 3'h7) |-> ##1 !serial_frame_pulse;
	endproperty

	a_frame_none: assert property (p_frame_none);
	property p_frame_none;
		@(posedge pclk) disable iff (!presetn)
		(frame_rate_reg[3:0] >= 4'ha)[*2] |-> !eng_pulse;
	endproperty

	a_reserved_bits: assert property (p_reserved_bits);
	property p_reserved_bits;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite) |-> (prdata[31:4] == 28'h0);
	endproperty
endmodule

/* tb_top.sv */
`include "audio_route_consts.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0]  paddr, pwdata, prdata;
	logic         quad_rate_tick, adc_valid, engine_slot_valid, tick_en;
	logic [23:0]  adc_left, adc_right, engine_in_left, engine_in_right;
	logic [191:0] engine_slot_data, tx_slot_data;
	logic         engine_in_valid, engine_frame_start, engine_pc_enable, engine_standby;
	logic         tx_slot_valid, serial_frame_pulse;
	logic [3:0]   port_pin_out, port_pin_oe_n, aux_pin_out, aux_pin_oe_n, pad_in;
	logic [3:0]   pad_out, pad_oe_n, pin_is_aux, port_pin_in, aux_pin_in;
	integer       seed;
	int           error_cnt, samples_checked, frame_cnt, serial_cnt, cycles;
	logic [32:0]  rd_q[$];
	logic [191:0] tx_q[$];

	audio_route_engine_ctrl dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.quad_rate_tick(quad_rate_tick), .adc_left(adc_left), .adc_right(adc_right),
		.adc_valid(adc_valid), .engine_slot_data(engine_slot_data),
		.engine_slot_valid(engine_slot_valid), .engine_in_left(engine_in_left),
		.engine_in_right(engine_in_right), .engine_in_valid(engine_in_valid),
		.engine_frame_start(engine_frame_start), .engine_pc_enable(engine_pc_enable),
		.engine_standby(engine_standby), .tx_slot_data(tx_slot_data), .tx_slot_valid(tx_slot_valid),
		.serial_frame_pulse(serial_frame_pulse), .port_pin_out(port_pin_out),
		.port_pin_oe_n(port_pin_oe_n), .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pin_is_aux(pin_is_aux),
		.port_pin_in(port_pin_in), .aux_pin_in(aux_pin_in)
	);

	// Free-running bus clock at 25 MHz.
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Rate tick every second cycle, so one base rate period is eight cycles.
	always @(posedge pclk) begin
		quad_rate_tick <= tick_en & ~quad_rate_tick;
	end

	// Pulse counters and the hang guard; the ceiling leaves about three times the expected run.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		frame_cnt <= frame_cnt + int'(engine_frame_start);
		serial_cnt <= serial_cnt + int'(serial_frame_pulse);
		if (cycles == 17000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// Results are matched against the oldest note as soon as they appear.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (rd_q.size() == 0) check(1, 0);
			else check({pslverr, prdata}, rd_q.pop_front());
		end
		if (tx_slot_valid === 1'b1) begin
			if (tx_q.size() == 0) check(1, 0);
			else check(tx_slot_data, tx_q.pop_front());
		end
	end

	task automatic check(input logic [191:0] seen, input logic [191:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [31:0] ba(input logic [15:0] idx);
		return {14'h0, idx, 2'b00};
	endfunction

	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] exp);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		if (!w) rd_q.push_back(exp);
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [31:0] a, input logic [32:0] exp);
		apb(1'b0, a, 32'h0, exp);
	endtask

	// Main sequence.
	initial begin
		logic [15:0]  idx_tab [5];
		logic [7:0]   msk_tab [5];
		int           per_tab [8];
		int           eng_tab [11];
		logic [23:0]  l, r;
		logic [191:0] sd, ex;
		logic [3:0]   role;
		int           p, n, n0, e;
		idx_tab = '{`IDX_FRAME_RATE, `IDX_OUT_ROUTE, `IDX_PIN_ROLE, `IDX_RUN, `IDX_SERIAL_RATE};
		msk_tab = '{`MASK_FRAME_RATE, `MASK_OUT_ROUTE, `MASK_PIN_ROLE, `MASK_RUN, `MASK_SERIAL_RATE};
		per_tab = '{4, 24, 16, 12, 8, 6, 2, 0};
		eng_tab = '{2, 4, 6, 8, 12, 16, 24, 4, 4, 1, 0};
		seed = 32'h9178;
		{error_cnt, samples_checked, frame_cnt, serial_cnt, cycles} = '0;
		{presetn, psel, penable, pwrite, paddr, pwdata, tick_en, quad_rate_tick} = '0;
		{adc_left, adc_right, adc_valid, engine_slot_data, engine_slot_valid} = '0;
		{port_pin_out, port_pin_oe_n, aux_pin_out, aux_pin_oe_n, pad_in} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check({engine_standby, engine_pc_enable, pin_is_aux}, 6'h20);
		for (int i = 0; i < 5; i++) begin
			rd(ba(idx_tab[i]), 33'h0);
			wr(ba(idx_tab[i]), 32'hffffffff);
			rd(ba(idx_tab[i]), {25'h0, msk_tab[i]});
			wr(ba(idx_tab[i]), 32'h0);
		end
		wr(ba(`IDX_ENGINE_STAT), 32'hff);
		rd(ba(`IDX_ENGINE_STAT), 33'h1);
		rd(ba(16'h40f5), 33'h100000000);
		rd(ba(`IDX_RUN) | 32'h2, 33'h100000000);
		// pin hand-over, last pass with every pin back on the port.
		for (int b = 0; b < 5; b++) begin
			role = 4'(5'h1 << b);
			wr(ba(`IDX_PIN_ROLE), {28'h0, role});
			@(posedge pclk);
			port_pin_out <= 4'($random(seed));
			port_pin_oe_n <= 4'($random(seed));
			aux_pin_out <= 4'($random(seed));
			aux_pin_oe_n <= 4'($random(seed));
			pad_in <= 4'($random(seed));
			@(posedge pclk);
			#1;
			check(pin_is_aux, role);
			check(pad_out, (aux_pin_out & role) | (port_pin_out & ~role));
			check(pad_oe_n, (aux_pin_oe_n & role) | (port_pin_oe_n & ~role));
			check({port_pin_in, aux_pin_in}, {pad_in & ~role, pad_in & role});
		end
		// every route code, engine and ADC offered together.
		for (int c = 0; c < 16; c++) begin
			wr(ba(`IDX_OUT_ROUTE), 32'(c));
			@(posedge pclk);
			l = 24'($random(seed));
			r = 24'($random(seed));
			sd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
			adc_left <= l;
			adc_right <= r;
			engine_slot_data <= sd;
			adc_valid <= 1'b1;
			engine_slot_valid <= 1'b1;
			p = c[2:1];
			ex = '0;
			ex[p*48 +: 24] = c[3] ? r : l;
			ex[p*48+24 +: 24] = c[3] ? l : r;
			if (c == 0) tx_q.push_back(sd);
			else if (c[0]) tx_q.push_back(ex);
			@(posedge pclk);
			adc_valid <= 1'b0;
			engine_slot_valid <= 1'b0;
			#1;
			check(engine_in_valid, c == 0);
			if (c == 0) check({engine_in_left, engine_in_right}, {l, r});
			repeat (2) @(posedge pclk);
		end
		// serial frame count over 96 rate ticks, one pulse of phase slack.
		tick_en <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			wr(ba(`IDX_SERIAL_RATE), 32'(k));
			repeat (48) @(posedge pclk);
			n0 = serial_cnt;
			repeat (192) @(posedge pclk);
			n = serial_cnt - n0;
			e = per_tab[k] ? 96 / per_tab[k] : 0;
			check(per_tab[k] ? (n >= e - 1 && n <= e + 1) : (n == 0), 1'b1);
		end
		// valid frame rate first, ticks held so the engine must wait armed.
		tick_en <= 1'b0;
		// serial port back at the base rate so it matches the engine rate.
		wr(ba(`IDX_SERIAL_RATE), 32'h0);
		wr(ba(`IDX_FRAME_RATE), 32'h1);
		wr(ba(`IDX_RUN), 32'h1);
		rd(ba(`IDX_ENGINE_STAT), 33'h2);
		#1;
		check(engine_pc_enable, 1'b0);
		tick_en <= 1'b1;
		n = 0;
		while (engine_pc_enable !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		#1;
		check(engine_pc_enable, 1'b1);
		rd(ba(`IDX_ENGINE_STAT), 33'h4);
		n0 = frame_cnt;
		repeat (160) @(posedge pclk);
		check((frame_cnt - n0) inside {[19:21]}, 1'b1);
		// Engine frame-rate codes 0 to 10; codes 7 and 8 follow the serial port at the base rate.
		for (int k = 0; k < 11; k++) begin
			wr(ba(`IDX_FRAME_RATE), 32'(k));
			repeat (48) @(posedge pclk);
			n0 = frame_cnt;
			repeat (192) @(posedge pclk);
			n = frame_cnt - n0;
			e = eng_tab[k] ? 96 / eng_tab[k] : 0;
			check(eng_tab[k] ? (n >= e - 1 && n <= e + 1) : (n == 0), 1'b1);
		end
		// stop order; the wait is shortened since the block keeps no timer.
		wr(ba(`IDX_FRAME_RATE), 32'h7f);
		repeat (4) @(posedge pclk);
		n0 = frame_cnt;
		repeat (200) @(posedge pclk);
		check(frame_cnt - n0, 0);
		wr(ba(`IDX_RUN), 32'h0);
		repeat (3) @(posedge pclk);
		#1;
		check({engine_standby, engine_pc_enable}, 2'b10);
		rd(ba(`IDX_ENGINE_STAT), 33'h1);
		repeat (4) @(posedge pclk);
		check(rd_q.size() + tx_q.size(), 0);
		end_of_test();
	end
endmodule
